/* pkg/timer16_regs.svh */
`ifndef TIMER16_REGS_SVH
`define TIMER16_REGS_SVH

// -----------------------------------------------------------------------
// Register byte offsets on the APB window.
// -----------------------------------------------------------------------
`define CFG_OFF 8'h00
`define MODE_OFF 8'h04
`define CTRL_OFF 8'h08
`define ILR_OFF 8'h0C
`define MATCH_OFF 8'h10
`define PRE_OFF 8'h14
`define VALUE_OFF 8'h18
`define MASK_OFF 8'h1C
`define RAW_OFF 8'h20
`define MIS_OFF 8'h24
`define CLR_OFF 8'h28

// -----------------------------------------------------------------------
// Field codes and reset values.
// -----------------------------------------------------------------------
`define CFG_16BIT 3'h4
`define MODE_ONESHOT 2'h1
`define MODE_PERIODIC 2'h2
`define MODE_CAPTURE 2'h3
`define EV_RISE 2'h0
`define EV_FALL 2'h1
`define ILR_RST 16'hFFFF
`define CNT_RST 16'hFFFF
`define MATCH_RST 16'hFFFF
`define PRE_RST 8'h00
`define CNT_ZERO 16'h0000
`define PRE_ZERO 8'h00

// -----------------------------------------------------------------------
// Status bit positions shared by mask, raw, masked and clear registers.
// -----------------------------------------------------------------------
`define TO_BIT 0
`define MATCH_BIT 1
`define EDGE_BIT 2

`endif

/* pkg/timer16_pkg.sv */
package timer16_pkg;

  // ---------------------------------------------------------------------
  // Mode register layout, bit 0 upward: mode field, capture, alternate.
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic alternate_mode_bit;
    logic capture_mode_bit;
    logic [1:0] timer_mode_field;
  } mode_bits_t;

  // Control register layout, bit 5 downward.
  typedef struct packed {
    logic pwm_level_invert;
    logic output_trigger_enable;
    logic [1:0] event_sel;
    logic stall_control_bit;
    logic enable;
  } ctrl_bits_t;

  // Decoded operating function of the half.
  typedef enum logic [2:0] {
    OP_IDLE,
    OP_TIMER,
    OP_ECOUNT,
    OP_ETIME,
    OP_PWM
  } op_t;

endpackage : timer16_pkg

/* rtl/timer16_capture_pwm.sv */
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`include "timer16_regs.svh"
// What this block does
// - Value 0x4 in config selects 16-bit mode.
// - Mode field: 1 one-shot, 2 periodic, 3 capture.
// - Reset: counter, load FFFF; prescale 00.
// - Timer modes count down, prescaler extends range.
// - At zero, reload load and prescale next cycle.
// - One-shot stops and clears enable; periodic continues.
// - Zero sets raw timeout flag until cleared.
// - Unmasked timeout sets masked flag and interrupt.
// - Timeout pulses trigger only when trigger enabled.
// - New load value enters counter next cycle.
// - Stall bit plus stall request freezes counter.
// - Prescale N gives N+1 clocks per count.
// - No prescaler in capture or PWM modes.
// - Capture bit 0 is edge count; event selects edges.
// - Edges decrement; at match flag, reload, disable.
// - After match, edges ignored until re-enabled.
// - Capture bit 1: free-running time capture, one edge type.
// - Selected edge copies counter, sets edge flag.
// - Time capture keeps counting, reloads at zero.
// - Captured value held until next selected edge.
// - PWM needs alternate 1, capture 0, mode 2.
// - PWM reloads after zero, raises no flags.
// - PWM high at load value, low at match.
module timer16_capture_pwm (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic ccp_i,
  input wire logic stall_req_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o,
  output logic trigger_o,
  output logic ccp_o,
  output logic ccp_oe_n_o
);

  // -----------------------------------------------------------------------
  // State.
  // -----------------------------------------------------------------------
  logic [2:0] cfg;
  timer16_pkg::mode_bits_t mode_r;
  timer16_pkg::ctrl_bits_t ctrl;
  logic [15:0] interval_load_value;
  logic [15:0] match_value;
  logic [7:0] prescale_value;
  logic [15:0] counter;
  logic [7:0] pre_cnt;
  logic [15:0] capture;
  logic [2:0] mask;
  logic [2:0] raw;
  logic load_pend;
  logic sync1, sync2, sync3;
  logic pwm_lvl;
  timer16_pkg::op_t op;
  logic access, wr, frozen, rise, fall, sel_edge, capture_sel;
  logic timeout_evt, match_evt, cap_evt;
  logic [15:0] next_counter;
  logic [7:0] next_pre;
  logic [2:0] next_raw;
  logic next_lvl;

  // Address compare used by every register write; the read mux decodes paddr_i in a case.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // Down-count with reload at zero, shared by time capture and PWM.
  function automatic logic [15:0] wrap_dec(input logic [15:0] c, input logic [15:0] ld);
    wrap_dec = (c == `CNT_ZERO) ? ld : c - 16'h0001;
  endfunction : wrap_dec

  // -----------------------------------------------------------------------
  // Bus qualifiers: a transfer completes at the edge where pready is high.
  // -----------------------------------------------------------------------
  assign access = psel_i & penable_i & pready_o;
  assign wr = access & pwrite_i;

  // Decode the operating function; nothing runs outside 16-bit mode.
  always_comb begin
    op = timer16_pkg::OP_IDLE;
    if (cfg == `CFG_16BIT && ctrl.enable) begin
      if (mode_r.alternate_mode_bit) begin
        if (!mode_r.capture_mode_bit &&
            mode_r.timer_mode_field == `MODE_PERIODIC) begin
          op = timer16_pkg::OP_PWM;
        end
      end else begin
        case (mode_r.timer_mode_field)
          `MODE_ONESHOT, `MODE_PERIODIC: op = timer16_pkg::OP_TIMER;
          `MODE_CAPTURE: op = mode_r.capture_mode_bit ?
              timer16_pkg::OP_ETIME : timer16_pkg::OP_ECOUNT;
          default: op = timer16_pkg::OP_IDLE;
        endcase
      end
    end
  end

  // -----------------------------------------------------------------------
  // Input synchroniser and edge detection.
  // -----------------------------------------------------------------------
  // Edges are only seen on the second and third stages, so an input that
  // holds each level two clocks is never missed.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= ccp_i;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign rise = sync2 & ~sync3;
  assign fall = ~sync2 & sync3;
  assign frozen = ctrl.stall_control_bit & stall_req_i;

  // Time capture never takes both edges; a both-edge code means rising.
  always_comb begin
    sel_edge = rise | fall;
    if (op == timer16_pkg::OP_ETIME) begin
      sel_edge = (ctrl.event_sel == `EV_FALL) ? fall : rise;
    end else if (ctrl.event_sel == `EV_RISE) begin
      sel_edge = rise;
    end else if (ctrl.event_sel == `EV_FALL) begin
      sel_edge = fall;
    end
  end

  // -----------------------------------------------------------------------
  // Counter datapath and event generation.
  // -----------------------------------------------------------------------
  // Prescale sits below the counter as one 24-bit chain: (load+1)*(N+1) clocks.
  always_comb begin
    next_counter = counter;
    next_pre = pre_cnt;
    timeout_evt = 1'b0;
    match_evt = 1'b0;
    cap_evt = 1'b0;
    if (load_pend) begin
      next_counter = interval_load_value;
      next_pre = prescale_value;
    end else if (!frozen) begin
      case (op)
        timer16_pkg::OP_TIMER: begin
          if (pre_cnt != `PRE_ZERO) begin
            next_pre = pre_cnt - 8'h01;
          end else if (counter == `CNT_ZERO) begin
            next_counter = interval_load_value;
            next_pre = prescale_value;
            timeout_evt = 1'b1;
          end else begin
            next_counter = counter - 16'h0001;
            next_pre = prescale_value;
          end
        end
        timer16_pkg::OP_ECOUNT: begin
          if (counter == match_value) begin
            match_evt = 1'b1;
            next_counter = interval_load_value;
          end else if (sel_edge) begin
            next_counter = counter - 16'h0001;
          end
        end
        timer16_pkg::OP_ETIME: begin
          cap_evt = sel_edge;
          next_counter = wrap_dec(counter, interval_load_value);
        end
        timer16_pkg::OP_PWM: next_counter = wrap_dec(counter, interval_load_value);
        default: next_counter = counter;
      endcase
    end
  end

  // Counter and prescale stage.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      counter <= `CNT_RST;
      pre_cnt <= `PRE_RST;
    end else begin
      counter <= next_counter;
      pre_cnt <= next_pre;
    end
  end

  // Captured edge time stays put until the next selected edge.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      capture <= `CNT_RST;
    end else if (cap_evt) begin
      capture <= counter;
    end
  end

  // A load value write is applied one cycle later, even when idle, so
  // software can preload the start value before setting enable.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      load_pend <= 1'b0;
    end else begin
      load_pend <= wr & hit(paddr_i, `ILR_OFF);
    end
  end

  // -----------------------------------------------------------------------
  // Software registers.
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg <= 3'h0;
      mode_r <= '0;
      interval_load_value <= `ILR_RST;
      match_value <= `MATCH_RST;
      prescale_value <= `PRE_RST;
      mask <= 3'h0;
    end else if (wr) begin
      if (hit(paddr_i, `CFG_OFF)) cfg <= pwdata_i[2:0];
      if (hit(paddr_i, `MODE_OFF)) mode_r <= pwdata_i[3:0];
      if (hit(paddr_i, `ILR_OFF)) interval_load_value <= pwdata_i[15:0];
      if (hit(paddr_i, `MATCH_OFF)) match_value <= pwdata_i[15:0];
      if (hit(paddr_i, `PRE_OFF)) prescale_value <= pwdata_i[7:0];
      if (hit(paddr_i, `MASK_OFF)) mask <= pwdata_i[2:0];
    end
  end

  // Hardware clears enable at a one-shot timeout or an edge count match;
  // a software write in the same cycle takes precedence.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= '0;
    end else if (wr && hit(paddr_i, `CTRL_OFF)) begin
      ctrl <= pwdata_i[5:0];
    end else if (match_evt ||
                 (timeout_evt && mode_r.timer_mode_field == `MODE_ONESHOT)) begin
      ctrl.enable <= 1'b0;
    end
  end

  // -----------------------------------------------------------------------
  // Status flags, interrupt and trigger.
  // -----------------------------------------------------------------------
  // Set beats clear so an event landing on the clear write is kept.
  always_comb begin
    next_raw = raw;
    if (wr && hit(paddr_i, `CLR_OFF)) begin
      next_raw = raw & ~pwdata_i[2:0];
    end
    next_raw[`TO_BIT] = next_raw[`TO_BIT] | timeout_evt;
    next_raw[`MATCH_BIT] = next_raw[`MATCH_BIT] | match_evt;
    next_raw[`EDGE_BIT] = next_raw[`EDGE_BIT] | cap_evt;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      raw <= 3'h0;
      irq_o <= 1'b0;
      trigger_o <= 1'b0;
    end else begin
      raw <= next_raw;
      irq_o <= |(next_raw & mask);
      trigger_o <= timeout_evt & ctrl.output_trigger_enable;
    end
  end

  // -----------------------------------------------------------------------
  // PWM output on the capture/compare pin.
  // -----------------------------------------------------------------------
  always_comb begin
    next_lvl = 1'b0;
    if (op == timer16_pkg::OP_PWM) begin
      next_lvl = pwm_lvl;
      if (counter == interval_load_value) begin
        next_lvl = 1'b1;
      end else if (counter == match_value) begin
        next_lvl = 1'b0;
      end
    end
  end

  // The pin is driven only while PWM runs; otherwise it is an input.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pwm_lvl <= 1'b0;
      ccp_o <= 1'b0;
      ccp_oe_n_o <= 1'b1;
    end else begin
      pwm_lvl <= next_lvl;
      ccp_o <= next_lvl ^ ctrl.pwm_level_invert;
      ccp_oe_n_o <= (op != timer16_pkg::OP_PWM);
    end
  end

  // -----------------------------------------------------------------------
  // APB slave: one wait state, then data and pready together.
  // -----------------------------------------------------------------------
  assign capture_sel = mode_r.capture_mode_bit && mode_r.timer_mode_field == `MODE_CAPTURE;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else begin
      pready_o <= psel_i & penable_i & ~pready_o;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
      if (psel_i && penable_i && !pready_o) begin
        case (paddr_i)
          `CFG_OFF: prdata_o <= {29'h0, cfg};
          `MODE_OFF: prdata_o <= {28'h0, mode_r};
          `CTRL_OFF: prdata_o <= {26'h0, ctrl};
          `ILR_OFF: prdata_o <= {16'h0, interval_load_value};
          `MATCH_OFF: prdata_o <= {16'h0, match_value};
          `PRE_OFF: prdata_o <= {24'h0, prescale_value};
          `VALUE_OFF: prdata_o <= {16'h0, capture_sel ? capture : counter};
          `MASK_OFF: prdata_o <= {29'h0, mask};
          `RAW_OFF: prdata_o <= {29'h0, raw};
          `MIS_OFF: prdata_o <= {29'h0, raw & mask};
          `CLR_OFF: prdata_o <= 32'h00000000;
          default: pslverr_o <= 1'b1;
        endcase
      end
    end
  end

  // -----------------------------------------------------------------------
  // Checks.
  // -----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_timeout_flag;
    timeout_evt |=> raw[`TO_BIT] && counter == $past(interval_load_value);
  endproperty
  a_timeout_flag: assert property (p_timeout_flag)
    else $error("timeout did not set flag and reload");
  property p_oneshot_stop;
    timeout_evt && mode_r.timer_mode_field == `MODE_ONESHOT &&
      !(wr && hit(paddr_i, `CTRL_OFF)) |=> !ctrl.enable;
  endproperty
  a_oneshot_stop: assert property (p_oneshot_stop)
    else $error("one-shot kept enable after timeout");
  property p_trigger;
    trigger_o |-> $past(timeout_evt) && $past(ctrl.output_trigger_enable);
  endproperty
  a_trigger: assert property (p_trigger)
    else $error("trigger without enabled timeout");
  property p_prescale_hold;
    op == timer16_pkg::OP_TIMER && !frozen && !load_pend &&
      pre_cnt != `PRE_ZERO && counter != `CNT_ZERO |=> $stable(counter);
  endproperty
  a_prescale_hold: assert property (p_prescale_hold)
    else $error("counter moved before prescale expired");
  property p_stall;
    frozen && !load_pend |=> $stable(counter) && $stable(pre_cnt);
  endproperty
  a_stall: assert property (p_stall)
    else $error("counter moved while stalled");
  property p_load;
    wr && hit(paddr_i, `ILR_OFF) |=> ##1 counter == $past(pwdata_i[15:0], 2);
  endproperty
  a_load: assert property (p_load)
    else $error("load value not applied one cycle after write");
  property p_match;
    match_evt && !(wr && hit(paddr_i, `CTRL_OFF)) |=>
      !ctrl.enable && raw[`MATCH_BIT] && counter == $past(interval_load_value);
  endproperty
  a_match: assert property (p_match)
    else $error("edge count match mishandled");
  property p_capture;
    cap_evt |=> capture == $past(counter) && raw[`EDGE_BIT];
  endproperty
  a_capture: assert property (p_capture)
    else $error("edge time capture wrong");
  property p_pwm_quiet;
    op == timer16_pkg::OP_PWM && !(wr && hit(paddr_i, `CLR_OFF)) |=> raw == $past(raw);
  endproperty
  a_pwm_quiet: assert property (p_pwm_quiet)
    else $error("status flag changed in PWM mode");
  property p_pwm_rise;
    op == timer16_pkg::OP_PWM && counter == interval_load_value |=>
      ccp_o == !$past(ctrl.pwm_level_invert) && !ccp_oe_n_o;
  endproperty
  a_pwm_rise: assert property (p_pwm_rise)
    else $error("PWM not asserted at load value");
endmodule : timer16_capture_pwm

/* verif/ccp_partner.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Capture pin source that sends a burst of pulses when asked.
// ---------------------------------------------------------------
module ccp_partner (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [3:0] pulses_i,
  output logic drive_o,
  output logic level_o,
  output logic busy_o
);
  // Each level is held three clocks, so no edge is ever too short.
  initial begin
    drive_o = 1'b0;
    level_o = 1'b0;
    busy_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (go_i === 1'b1) begin
        busy_o <= 1'b1;
        drive_o <= 1'b1;
        for (int i = 0; i < pulses_i; i++) begin
          level_o <= 1'b1;
          repeat (3) @(posedge clk_i);
          level_o <= 1'b0;
          repeat (3) @(posedge clk_i);
        end
        drive_o <= 1'b0; // Released, so the pull-down owns the pin.
        busy_o <= 1'b0;
      end
    end
  end
endmodule : ccp_partner

/* verif/timer16_capture_pwm_test.sv */
`timescale 1ns/1ps
`include "timer16_regs.svh"
module timer16_capture_pwm_test;
  logic clk_i, rst_i, psel, penable, pwrite, stall_req, go, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata, v1;
  logic [3:0] npulse;
  logic prdy, perr, irq, trig, pwm, pwm_oe_n, drv, lvl, busy, pin;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0, tcount = 0, tlast = 0, tgap = 0, hi;

  // Pin level: the block when it drives, else the source, else pull-down.
  assign pin = !pwm_oe_n ? pwm : (drv ? lvl : 1'b0);

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  timer16_capture_pwm i_timer16_capture_pwm (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .ccp_i(pin), .stall_req_i(stall_req), .prdata_o(prdata), .pready_o(prdy),
    .pslverr_o(perr), .irq_o(irq), .trigger_o(trig), .ccp_o(pwm), .ccp_oe_n_o(pwm_oe_n));

  ccp_partner i_ccp_partner (.clk_i(clk_i), .go_i(go), .pulses_i(npulse), .drive_o(drv),
    .level_o(lvl), .busy_o(busy));

  // Trigger pulses are counted and their spacing kept for period checks.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (trig === 1'b1) begin
      tcount <= tcount + 1;
      tgap <= cyc - tlast;
      tlast <= cyc;
    end
  end

  task summarize;
    if (num_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; data and error are taken at the pready edge only.
  // The wait is open ended so that only the watchdog can end a hang.
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (prdy !== 1'b1);
    rdata = prdata;
    rerr = perr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask : rdchk

  // Polls a raw status bit; a dead flag is caught by the watchdog.
  task wait_raw(input int b);
    do begin
      apb(1'b0, `RAW_OFF, 32'h0);
    end while (rdata[b] !== 1'b1);
  endtask : wait_raw

  // Asks the pin source for a burst and lets the synchroniser settle.
  task pulse(input logic [3:0] cnt);
    @(posedge clk_i);
    go <= 1'b1;
    npulse <= cnt;
    @(posedge clk_i);
    go <= 1'b0;
    do begin
      @(posedge clk_i);
    end while (busy !== 1'b0);
    repeat (6) @(posedge clk_i);
  endtask : pulse

  initial begin
    #400000;
    num_errors++;
    summarize();
  end

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    stall_req = 1'b0;
    go = 1'b0;
    npulse = 4'h0;
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(`ILR_OFF, 32'h0000FFFF);
    rdchk(`VALUE_OFF, 32'h0000FFFF);
    rdchk(`PRE_OFF, 32'h00000000);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    wr(`CFG_OFF, 32'h4);
    // One-shot run with trigger and unmasked timeout.
    wr(`MODE_OFF, 32'h1);
    wr(`ILR_OFF, 32'h5);
    wr(`MASK_OFF, 32'h1);
    tcount = 0;
    wr(`CTRL_OFF, 32'h11);
    wait_raw(`TO_BIT);
    repeat (20) @(posedge clk_i);
    chk(tcount, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rdchk(`CTRL_OFF, 32'h10);
    rdchk(`VALUE_OFF, 32'h5);
    rdchk(`MIS_OFF, 32'h1);
    rdchk(`RAW_OFF, 32'h1);
    wr(`CLR_OFF, 32'h1);
    rdchk(`RAW_OFF, 32'h0);
    // Periodic spacing of timeouts for two prescale settings.
    wr(`MODE_OFF, 32'h2);
    for (int p = 0; p < 4; p += 3) begin
      wr(`PRE_OFF, p);
      wr(`ILR_OFF, 32'h4);
      tcount = 0;
      wr(`CTRL_OFF, 32'h11);
      while (tcount < 3) begin
        @(posedge clk_i);
      end
      chk(tgap, 5 * (p + 1));
      wr(`CTRL_OFF, 32'h0);
    end
    // Stall freeze, load while running, and trigger disabled.
    wr(`CLR_OFF, 32'h7);
    wr(`ILR_OFF, 32'h0FFF);
    stall_req <= 1'b1;
    tcount = 0;
    wr(`CTRL_OFF, 32'h3);
    rdchk(`VALUE_OFF, 32'h0FFF);
    repeat (10) @(posedge clk_i);
    rdchk(`VALUE_OFF, 32'h0FFF);
    stall_req <= 1'b0;
    wr(`ILR_OFF, 32'h0100);
    rdchk(`VALUE_OFF, 32'h100);
    wr(`ILR_OFF, 32'h4);
    repeat (60) @(posedge clk_i);
    chk(tcount, 32'h0);
    rdchk(`RAW_OFF, 32'h1);
    wr(`CTRL_OFF, 32'h0);
    wr(`CLR_OFF, 32'h7);
    // Edge counting for each event selection.
    wr(`MODE_OFF, 32'h3);
    wr(`MATCH_OFF, 32'h0);
    for (int e = 0; e < 3; e++) begin
      wr(`ILR_OFF, 32'h5);
      wr(`CTRL_OFF, e * 4 + 1);
      pulse(4'h2);
      rdchk(`VALUE_OFF, (e == 2) ? 32'h1 : 32'h3);
      wr(`CTRL_OFF, 32'h0);
    end
    // Match stops counting; later edges are ignored.
    wr(`ILR_OFF, 32'hA);
    wr(`MATCH_OFF, 32'h6);
    wr(`MASK_OFF, 32'h2);
    wr(`CTRL_OFF, 32'h9);
    pulse(4'h3);
    rdchk(`VALUE_OFF, 32'hA);
    rdchk(`CTRL_OFF, 32'h8);
    rdchk(`RAW_OFF, 32'h2);
    rdchk(`MIS_OFF, 32'h2);
    pulse(4'h2);
    rdchk(`VALUE_OFF, 32'hA);
    wr(`CLR_OFF, 32'h7);
    wr(`MASK_OFF, 32'h0);
    // Edge time capture on rising edges.
    wr(`MODE_OFF, 32'h7);
    wr(`ILR_OFF, 32'hFFFF);
    wr(`CTRL_OFF, 32'h1);
    pulse(4'h1);
    apb(1'b0, `VALUE_OFF, 32'h0);
    v1 = rdata;
    repeat (10) @(posedge clk_i);
    rdchk(`VALUE_OFF, v1);
    rdchk(`RAW_OFF, 32'h4);
    pulse(4'h1);
    apb(1'b0, `VALUE_OFF, 32'h0);
    chk({31'h0, rdata < v1}, 32'h1);
    wr(`CTRL_OFF, 32'h0);
    wr(`CLR_OFF, 32'h7);
    // PWM duty, plain and inverted; prescale 3 is still programmed.
    wr(`MODE_OFF, 32'hA);
    wr(`ILR_OFF, 32'h9);
    wr(`MATCH_OFF, 32'h3);
    for (int inv = 0; inv < 2; inv++) begin
      wr(`CTRL_OFF, inv ? 32'h21 : 32'h01);
      repeat (30) @(posedge clk_i);
      hi = 0;
      repeat (20) begin
        @(posedge clk_i);
        hi += pwm;
      end
      chk(hi, inv ? 32'h8 : 32'hC);
      chk({31'h0, pwm_oe_n}, 32'h0);
      wr(`CTRL_OFF, 32'h0);
    end
    rdchk(`RAW_OFF, 32'h0);
    summarize();
  end
endmodule : timer16_capture_pwm_test
